// ---- hdl/coh_consts.svh ----
// Offsets, reset values, field positions and timing figures of the option block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef COH_CONSTS_SVH
`define COH_CONSTS_SVH

// Byte addresses of the two-byte settings (low byte even, high byte odd)
`define COH_ADDR_OPT0_LO 8'h00
`define COH_ADDR_OPT0_HI 8'h01
`define COH_ADDR_CUR_LO 8'h02
`define COH_ADDR_CUR_HI 8'h03
`define COH_ADDR_VLT_LO 8'h04
`define COH_ADDR_VLT_HI 8'h05
`define COH_ADDR_OPT1_LO 8'h30
`define COH_ADDR_OPT1_HI 8'h31

// Reset values
`define COH_RST_OPT0_LO 8'h0e
`define COH_RST_OPT0_HI 8'he2
`define COH_RST_OPT1_LO 8'h00
`define COH_RST_OPT1_HI 8'h00
`define COH_RST_CUR 16'h0000
`define COH_RST_VLT 16'h0000

// Field positions in the high option byte
`define COH_BIT_LOW_POWER 7
`define COH_BIT_WD_HI 6
`define COH_BIT_WD_LO 5
`define COH_BIT_AUTO_OFF 4
`define COH_BIT_REV_GOOD 3
`define COH_BIT_OOA 2
`define COH_BIT_RATE 1
// Field in the low option byte
`define COH_BIT_LOOP_ON 1
// Comparator enables in the high byte of option one
`define COH_BIT_CMP_A 6
`define COH_BIT_CMP_B 5

// Watchdog period codes
`define COH_WD_OFF 2'b00
`define COH_WD_SHORT 2'b01
`define COH_WD_MID 2'b10
`define COH_WD_LONG 2'b11

// Watchdog periods in seconds, clock rate in hertz
`define COH_WD_SHORT_S 5
`define COH_WD_MID_S 88
`define COH_WD_LONG_S 175
`define COH_CLK_HZ 125000000

`endif

// ---- hdl/coh_pkg.sv ----
// Types shared by the option block and its watchdog.
// Assumes the constants header sits beside it.
`include "coh_consts.svh"

package coh_pkg;

    // One byte write as decoded by the serial host port
    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } coh_wr_t;

    // Enables that other registers request for the monitor blocks
    typedef struct packed {
        logic prochot_en;
        logic dchg_mon_en;
        logic pwr_mon_en;
        logic cmp_en;
        logic adc_en;
    } coh_perf_t;

endpackage

// ---- hdl/coh_wdog.sv ----
// Charge watchdog: counts the selected period and flags expiry.
// Assumes the kick is a one-cycle pulse per qualifying committed write.
`include "coh_consts.svh"
module coh_wdog
    import coh_pkg::*;
#(
    parameter int CNT_W = 35,
    parameter logic [63:0] SHORT_CYC = 64'd625000000,
    parameter logic [63:0] MID_CYC = 64'd11000000000,
    parameter logic [63:0] LONG_CYC = 64'd21875000000
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [1:0] i_period,
    input wire logic i_kick,
    output logic o_expired_r,
    output logic o_expire_pulse_r
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] limit;
    logic wd_on;
    logic hit;

    // [R07] period code decode
    assign limit = (i_period == `COH_WD_SHORT) ? SHORT_CYC[CNT_W-1:0] :
                   (i_period == `COH_WD_MID) ? MID_CYC[CNT_W-1:0] :
                   LONG_CYC[CNT_W-1:0];
    assign wd_on = (i_period != `COH_WD_OFF);
    assign hit = wd_on && !o_expired_r && (count_r == limit - CNT_W'(1));

    // [R13] restart from zero on kick
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || i_kick || !wd_on || o_expired_r) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + CNT_W'(1);
        end
    end

    // [R06] kick clears an expiry; a disabled watchdog never stays expired
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || i_kick || !wd_on) begin
            o_expired_r <= 1'b0;
            o_expire_pulse_r <= 1'b0;
        end else begin
            o_expired_r <= o_expired_r | hit;
            o_expire_pulse_r <= hit;
        end
    end

endmodule

// ---- hdl/coh_top.sv ----
// Upper option byte control: pairing of byte writes, low-power gating,
// charge watchdog, input-limit auto-off, charge-ok and converter selects.
// Assumes byte writes and reads arrive decoded from the serial port, one per cycle.
//
// How it works
// [R01] Low byte first, then high; both commit together; high-first sequences are ignored.
// [R02] Low power off with battery only: monitors follow their own register requests.
// [R03] Low power on with battery only: prochot, monitors, comparator off, no ADC.
// [R04] In low power, either designated option-one bit still enables the comparator.
// [R05] No current or voltage write within the period forces current to zero.
// [R06] After expiry, current, voltage or period writes restart it; valid values resume.
// [R07] Period code: off, 5 s, 88 s, 175 s; reset selects 175 s.
// [R08] Auto-off set and battery pin falling clears the input-limit loop enable.
// [R09] Reverse-mode flag set drives charge-ok high during OTG operation.
// [R10] Out-of-audio set keeps burst rate above 25 kHz; clear gives no limit.
// [R11] Rate bit zero selects 1200 kHz, one selects 800 kHz; resets to one.
// [R12] Host programs the rate bit after each power-on reset to suit the inductor.
// [R13] Each qualifying write restarts the watchdog count from zero.
`include "coh_consts.svh"
module coh_top
    import coh_pkg::*;
#(
    parameter logic [63:0] WD_SHORT_CYC = 64'(`COH_WD_SHORT_S) * 64'(`COH_CLK_HZ),
    parameter logic [63:0] WD_MID_CYC = 64'(`COH_WD_MID_S) * 64'(`COH_CLK_HZ),
    parameter logic [63:0] WD_LONG_CYC = 64'(`COH_WD_LONG_S) * 64'(`COH_CLK_HZ),
    parameter int WD_CNT_W = 35
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire coh_wr_t i_wr,
    input wire logic [7:0] i_rd_addr,
    input wire coh_perf_t i_perf_req,
    input wire logic i_battery_only,
    input wire logic i_battery_present_cell_pin,
    input wire logic i_otg_active,
    input wire logic i_adapter_present,
    input wire logic i_values_valid,
    output logic [7:0] o_rd_data,
    output coh_perf_t o_perf_ctrl,
    output logic o_adapter_good_output,
    output logic o_charging_on,
    output logic [15:0] o_charge_current_setting,
    output logic o_input_limit_loop_on,
    output logic o_pulse_skip_burst_floor,
    output logic o_switching_rate_800k
);

    logic [7:0] opt0_lo_r, opt0_hi_r, opt1_lo_r, opt1_hi_r;
    logic [15:0] cur_r, vlt_r;
    logic pend_r;
    logic [7:0] pend_addr_r, pend_data_r;
    logic batp_d_r;
    logic wd_expired, wd_pulse;
    // Reset bytes held as typed constants so single bits can be picked out
    localparam logic [7:0] RST_LO = `COH_RST_OPT0_LO;
    localparam logic [7:0] RST_HI = `COH_RST_OPT0_HI;

    // Pairing decode: a high byte commits only after its own low byte
    logic wr_lo, wr_hi, pair_ok;
    logic [7:0] base;
    logic c_opt0, c_cur, c_vlt, c_opt1, kick;
    assign wr_lo = i_wr.stb && !i_wr.addr[0];
    assign wr_hi = i_wr.stb && i_wr.addr[0];
    assign base = {i_wr.addr[7:1], 1'b0};
    // [R01] commit only on matching pair
    assign pair_ok = wr_hi && pend_r && (pend_addr_r == base);
    assign c_opt0 = pair_ok && (base == `COH_ADDR_OPT0_LO);
    assign c_cur = pair_ok && (base == `COH_ADDR_CUR_LO);
    assign c_vlt = pair_ok && (base == `COH_ADDR_VLT_LO);
    assign c_opt1 = pair_ok && (base == `COH_ADDR_OPT1_LO);
    // [R06] qualifying writes restart the watchdog
    assign kick = c_opt0 || c_cur || c_vlt;

    // Low-power and auto-off decode
    logic lp, batp_fall, auto_clr, loop_nxt;
    logic [7:0] opt0_lo_nxt;
    logic [15:0] cur_nxt;
    assign lp = opt0_hi_r[`COH_BIT_LOW_POWER] && i_battery_only;
    assign batp_fall = batp_d_r && !i_battery_present_cell_pin;
    // [R08] pin fall clears loop enable, wins over a host write
    assign auto_clr = opt0_hi_r[`COH_BIT_AUTO_OFF] && batp_fall;
    assign opt0_lo_nxt = c_opt0 ? pend_data_r : opt0_lo_r;
    assign loop_nxt = opt0_lo_nxt[`COH_BIT_LOOP_ON] && !auto_clr;
    // [R05] expiry forces the current setting to zero
    assign cur_nxt = wd_pulse ? `COH_RST_CUR :
                     c_cur ? {i_wr.data, pend_data_r} : cur_r;

    // Pending low byte; any low write replaces it, any high write consumes it
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pend_r <= 1'b0;
            pend_addr_r <= 8'h00;
            pend_data_r <= 8'h00;
        end else if (wr_lo) begin
            pend_r <= 1'b1;
            pend_addr_r <= i_wr.addr;
            pend_data_r <= i_wr.data;
        end else if (wr_hi) begin
            pend_r <= 1'b0;
        end
    end

    // Stored settings; both bytes land in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            opt0_lo_r <= `COH_RST_OPT0_LO;
            opt0_hi_r <= `COH_RST_OPT0_HI;
            opt1_lo_r <= `COH_RST_OPT1_LO;
            opt1_hi_r <= `COH_RST_OPT1_HI;
            cur_r <= `COH_RST_CUR;
            vlt_r <= `COH_RST_VLT;
            batp_d_r <= 1'b1;
        end else begin
            opt0_lo_r <= {opt0_lo_nxt[7:2], loop_nxt, opt0_lo_nxt[0]};
            opt0_hi_r <= c_opt0 ? i_wr.data : opt0_hi_r;
            opt1_lo_r <= c_opt1 ? pend_data_r : opt1_lo_r;
            opt1_hi_r <= c_opt1 ? i_wr.data : opt1_hi_r;
            cur_r <= cur_nxt;
            vlt_r <= c_vlt ? {i_wr.data, pend_data_r} : vlt_r;
            batp_d_r <= i_battery_present_cell_pin;
        end
    end

    // Watchdog period field steers the timer; large counts stay parameters
    coh_wdog #(
        .CNT_W(WD_CNT_W),
        .SHORT_CYC(WD_SHORT_CYC),
        .MID_CYC(WD_MID_CYC),
        .LONG_CYC(WD_LONG_CYC)
    ) u_wdog (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_period(opt0_hi_r[`COH_BIT_WD_HI:`COH_BIT_WD_LO]),
        .i_kick(kick),
        .o_expired_r(wd_expired),
        .o_expire_pulse_r(wd_pulse)
    );

    // Read mux; unmapped offsets read zero
    logic [7:0] rd_nxt;
    assign rd_nxt = (i_rd_addr == `COH_ADDR_OPT0_LO) ? opt0_lo_r :
                    (i_rd_addr == `COH_ADDR_OPT0_HI) ? opt0_hi_r :
                    (i_rd_addr == `COH_ADDR_CUR_LO) ? cur_r[7:0] :
                    (i_rd_addr == `COH_ADDR_CUR_HI) ? cur_r[15:8] :
                    (i_rd_addr == `COH_ADDR_VLT_LO) ? vlt_r[7:0] :
                    (i_rd_addr == `COH_ADDR_VLT_HI) ? vlt_r[15:8] :
                    (i_rd_addr == `COH_ADDR_OPT1_LO) ? opt1_lo_r :
                    (i_rd_addr == `COH_ADDR_OPT1_HI) ? opt1_hi_r : 8'h00;

    // Monitor gating in low power
    coh_perf_t perf_nxt;
    logic cmp_keep;
    assign cmp_keep = opt1_hi_r[`COH_BIT_CMP_A] || opt1_hi_r[`COH_BIT_CMP_B];
    // [R02] [R03] gate monitors by power mode
    assign perf_nxt.prochot_en = i_perf_req.prochot_en && !lp;
    assign perf_nxt.dchg_mon_en = i_perf_req.dchg_mon_en && !lp;
    assign perf_nxt.pwr_mon_en = i_perf_req.pwr_mon_en && !lp;
    assign perf_nxt.adc_en = i_perf_req.adc_en && !lp;
    // [R04] comparator kept by option one
    assign perf_nxt.cmp_en = lp ? cmp_keep : i_perf_req.cmp_en;

    // Output flops; every output is registered so downstream sees clean levels
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rd_data <= 8'h00;
            o_perf_ctrl <= '0;
            o_adapter_good_output <= 1'b0;
            o_charging_on <= 1'b0;
            o_charge_current_setting <= `COH_RST_CUR;
            o_input_limit_loop_on <= RST_LO[`COH_BIT_LOOP_ON];
            o_pulse_skip_burst_floor <= RST_HI[`COH_BIT_OOA];
            o_switching_rate_800k <= RST_HI[`COH_BIT_RATE];
        end else begin
            o_rd_data <= rd_nxt;
            o_perf_ctrl <= perf_nxt;
            // [R09] OTG drives charge-ok when flagged
            o_adapter_good_output <= i_adapter_present ||
                (opt0_hi_r[`COH_BIT_REV_GOOD] && i_otg_active);
            // [R06] resume only with valid values
            o_charging_on <= !wd_expired && i_values_valid && (cur_r != `COH_RST_CUR);
            o_charge_current_setting <= cur_r;
            o_input_limit_loop_on <= opt0_lo_r[`COH_BIT_LOOP_ON];
            // [R10] burst floor select
            o_pulse_skip_burst_floor <= opt0_hi_r[`COH_BIT_OOA];
            // [R11] converter rate select
            o_switching_rate_800k <= opt0_hi_r[`COH_BIT_RATE];
        end
    end

    // Checks on the guarded behaviour
    a_high_first_ignored: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R01]
        (wr_hi && !pend_r && i_wr.addr == `COH_ADDR_OPT0_HI) |=> $stable(opt0_hi_r))
        else $error("high byte without low byte changed the option");
    a_perf_follows_req: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R02]
        (!opt0_hi_r[`COH_BIT_LOW_POWER] && i_battery_only)
        |=> o_perf_ctrl.prochot_en == $past(i_perf_req.prochot_en))
        else $error("performance mode did not follow request");
    a_lp_gates_mon: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R03]
        lp |=> !o_perf_ctrl.prochot_en && !o_perf_ctrl.adc_en &&
            !o_perf_ctrl.pwr_mon_en && !o_perf_ctrl.dchg_mon_en)
        else $error("low power left a monitor on");
    a_lp_cmp_keep: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R04]
        (lp && cmp_keep) |=> o_perf_ctrl.cmp_en)
        else $error("comparator not kept in low power");
    a_wd_zero_cur: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R05]
        wd_pulse |=> cur_r == `COH_RST_CUR ##1 !o_charging_on)
        else $error("expiry did not clear charge current");
    a_kick_clears: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R06]
        (kick && wd_expired) |=> !wd_expired)
        else $error("qualifying write did not restart watchdog");
    a_wd_off_code: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R07]
        (opt0_hi_r[`COH_BIT_WD_HI:`COH_BIT_WD_LO] == `COH_WD_OFF) |=> !wd_pulse)
        else $error("disabled watchdog expired");
    a_auto_off_clr: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R08]
        auto_clr |=> !opt0_lo_r[`COH_BIT_LOOP_ON] ##1 !o_input_limit_loop_on)
        else $error("auto-off did not clear loop enable");
    a_otg_good: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R09]
        (opt0_hi_r[`COH_BIT_REV_GOOD] && i_otg_active) |=> o_adapter_good_output)
        else $error("charge-ok not driven in OTG");
    a_burst_select: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R10]
        c_opt0 |=> ##1 o_pulse_skip_burst_floor == $past(i_wr.data[`COH_BIT_OOA], 2))
        else $error("burst floor not taken from write");
    a_rate_select: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R11]
        c_opt0 |=> ##1 o_switching_rate_800k == $past(i_wr.data[`COH_BIT_RATE], 2))
        else $error("rate select not taken from write");
    c_pair_commit: cover property (@(posedge i_ref_clk) disable iff (i_reset) c_opt0);
    c_wd_expiry: cover property (@(posedge i_ref_clk) disable iff (i_reset) wd_pulse);
    c_auto_off: cover property (@(posedge i_ref_clk) disable iff (i_reset) auto_clr);
    c_lp_cmp: cover property (@(posedge i_ref_clk) disable iff (i_reset) lp && cmp_keep);

endmodule

// ---- verif/coh_host.sv ----
// Host model: byte writes and reads on the decoded serial port.
// Assumes the bench makes the clock; drives only on falling edges.
module coh_host
    import coh_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rd_data,
    output coh_wr_t o_wr,
    output logic [7:0] o_rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_wr = '0;
        o_rd_addr = 8'h00;
    end
    // Lone byte, only to send a stray high byte
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_wr = '{stb: 1'b1, addr: a, data: d};
        @(negedge i_ref_clk);
        o_wr = '{stb: 1'b0, addr: ~a, data: ~d}; // Stale data never looks valid
    endtask
    // low byte first, high byte next
    task automatic wr_pair(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_ref_clk);
        o_wr = '{stb: 1'b1, addr: a, data: d[7:0]};
        @(negedge i_ref_clk);
        o_wr = '{stb: 1'b1, addr: a + 8'h01, data: d[15:8]};
        @(negedge i_ref_clk);
        o_wr = '{stb: 1'b0, addr: ~a, data: ~d[15:8]};
    endtask
    // Read data is registered, so it is taken one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        o_rd_addr = a;
        @(negedge i_ref_clk);
        d = i_rd_data;
    endtask
endmodule

// ---- verif/coh_top_bench.sv ----
// Bench for the upper option byte: pairing, gating, pins, watchdog.
// Assumes short watchdog periods of 40, 80 and 120 cycles.
module coh_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import coh_pkg::*;
    logic i_ref_clk, i_reset, i_battery_only, i_battery_present_cell_pin;
    logic i_otg_active, i_adapter_present, i_values_valid, ok;
    logic o_adapter_good_output, o_charging_on, o_input_limit_loop_on;
    logic o_pulse_skip_burst_floor, o_switching_rate_800k;
    logic [7:0] rd_addr, o_rd_data, rd_val;
    logic [15:0] o_charge_current_setting;
    coh_perf_t i_perf_req, o_perf_ctrl;
    coh_wr_t wr;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    int c;

    coh_top #(.WD_SHORT_CYC(64'd40), .WD_MID_CYC(64'd80), .WD_LONG_CYC(64'd120),
        .WD_CNT_W(35)) i_coh_top (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_wr(wr), .i_rd_addr(rd_addr), .i_perf_req(i_perf_req),
        .i_battery_only(i_battery_only),
        .i_battery_present_cell_pin(i_battery_present_cell_pin),
        .i_otg_active(i_otg_active), .i_adapter_present(i_adapter_present),
        .i_values_valid(i_values_valid), .o_rd_data(o_rd_data),
        .o_perf_ctrl(o_perf_ctrl), .o_adapter_good_output(o_adapter_good_output),
        .o_charging_on(o_charging_on), .o_charge_current_setting(o_charge_current_setting),
        .o_input_limit_loop_on(o_input_limit_loop_on),
        .o_pulse_skip_burst_floor(o_pulse_skip_burst_floor),
        .o_switching_rate_800k(o_switching_rate_800k));
    coh_host i_coh_host (.i_ref_clk(i_ref_clk), .i_rd_data(o_rd_data), .o_wr(wr),
        .o_rd_addr(rd_addr));

    // Clock, 8 ns period
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // Derived outputs lag the high byte by two edges
    task automatic settle();
        repeat (3) @(negedge i_ref_clk);
    endtask
    task automatic opt0(input logic [7:0] hi);
        i_coh_host.wr_pair(8'h00, {hi, 8'h0e});
        settle();
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        i_reset = 1'b1;
        i_battery_only = 1'b1;
        i_battery_present_cell_pin = 1'b1;
        i_otg_active = 1'b1;
        i_adapter_present = 1'b0;
        i_values_valid = 1'b1;
        i_perf_req = 5'h1f;
        repeat (20) @(negedge i_ref_clk);
        i_reset = 1'b0;
        i_coh_host.rd(8'h01, rd_val);
        chk("opt0 high", 8'he2, rd_val);
        chk("rate 800k", 1'b1, o_switching_rate_800k);
        chk("burst floor", 1'b0, o_pulse_skip_burst_floor);
        chk("perf gated", 5'h00, o_perf_ctrl);
        chk("good", 1'b0, o_adapter_good_output);
        i_coh_host.rd(8'h10, rd_val);
        chk("unmapped", 8'h00, rd_val);
        // Gating applies only while running from the battery alone
        i_battery_only = 1'b0;
        settle();
        chk("perf no battery", 5'h1f, o_perf_ctrl);
        i_battery_only = 1'b1;
        settle();
        i_coh_host.wr_byte(8'h01, 8'h00);
        i_coh_host.rd(8'h01, rd_val);
        chk("stray high", 8'he2, rd_val);
        $display("test reset and pairing done");
        // Either option-one bit keeps the comparator in low power
        for (n = 0; n < 2; n++) begin
            i_coh_host.wr_pair(8'h30, {8'h40 >> n, 8'h00});
            settle();
            chk("cmp kept", 5'h02, o_perf_ctrl);
        end
        opt0(8'h60);
        chk("rate 1200k", 1'b0, o_switching_rate_800k);
        chk("perf follow", 5'h1f, o_perf_ctrl);
        i_perf_req = 5'h0a;
        settle();
        chk("perf follow", 5'h0a, o_perf_ctrl);
        opt0(8'h64);
        chk("burst floor", 1'b1, o_pulse_skip_burst_floor);
        opt0(8'h68);
        chk("good otg", 1'b1, o_adapter_good_output);
        $display("test gating and selects done");
        // Pin falling clears the loop only with auto-off set
        opt0(8'h70);
        i_battery_present_cell_pin = 1'b0;
        settle();
        chk("loop auto off", 1'b0, o_input_limit_loop_on);
        i_battery_present_cell_pin = 1'b1;
        opt0(8'h60);
        chk("good otg off", 1'b0, o_adapter_good_output);
        // Normal charge-ok source still passes through
        i_adapter_present = 1'b1;
        settle();
        chk("good adapter", 1'b1, o_adapter_good_output);
        i_adapter_present = 1'b0;
        i_battery_present_cell_pin = 1'b0;
        settle();
        chk("loop kept", 1'b1, o_input_limit_loop_on);
        $display("test auto-off done");
        // Expiry time for each period code
        for (c = 1; c < 4; c++) begin
            opt0(8'(c << 5));
            i_coh_host.wr_pair(8'h02, 16'h0040);
            settle();
            chk("charging resumed", 1'b1, o_charging_on);
            n = 3;
            while (o_charging_on === 1'b1 && n < 400) begin
                @(negedge i_ref_clk);
                n++;
            end
            ok = (n >= 40 * c) && (n <= 40 * c + 5);
            chk("expiry in period", 1'b1, ok);
            // Current output copies the cleared setting one edge after charging drops
            @(negedge i_ref_clk);
            chk("current zeroed", 16'h0000, o_charge_current_setting);
        end
        // Voltage writes every 28 cycles keep the 40-cycle period alive
        opt0(8'h20);
        i_coh_host.wr_pair(8'h02, 16'h0040);
        for (n = 0; n < 3; n++) begin
            repeat (25) @(negedge i_ref_clk);
            i_coh_host.wr_pair(8'h04, 16'h1000);
            chk("still charging", 1'b1, o_charging_on);
        end
        repeat (60) @(negedge i_ref_clk);
        chk("expired after writes", 1'b0, o_charging_on);
        i_values_valid = 1'b0;
        i_coh_host.wr_pair(8'h02, 16'h0040);
        settle();
        chk("invalid no resume", 1'b0, o_charging_on);
        i_values_valid = 1'b1;
        opt0(8'h00);
        i_coh_host.wr_pair(8'h02, 16'h0040);
        repeat (200) @(negedge i_ref_clk);
        chk("watchdog off", 1'b1, o_charging_on);
        $display("test watchdog done");
        close_out();
    end
endmodule
